// >>> hw/tcw_pkg.sv
// Shared constants and types for the timer/compare waveform unit
package tcw_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_COUNT   = 8'h04;
    localparam logic [7:0] ADDR_COMPARE = 8'h08;
    localparam logic [7:0] ADDR_FLAGS   = 8'h0C;
    localparam logic [7:0] ADDR_PORT    = 8'h10;
    // Control register fields
    localparam int CTRL_FORCE_BIT = 7;
    localparam int CTRL_WGM0_BIT  = 6;
    localparam int CTRL_COM_LSB   = 4;
    localparam int CTRL_WGM1_BIT  = 3;
    localparam int CTRL_CS_LSB    = 0;
    // Flag and port register fields
    localparam int FLAG_WRAP_BIT  = 0;
    localparam int FLAG_MATCH_BIT = 1;
    localparam int PORT_DIR_BIT   = 0;
    localparam int PORT_DATA_BIT  = 1;
    // Count extremes and reset values
    localparam logic [7:0] COUNT_MAX    = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] RST_BYTE     = 8'h00;
    // Prescaler tap masks (divide by 8, 64, 256, 1024)
    localparam logic [9:0] PRE_MASK_8    = 10'h007;
    localparam logic [9:0] PRE_MASK_64   = 10'h03F;
    localparam logic [9:0] PRE_MASK_256  = 10'h0FF;
    localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;
    // Clock source selections
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_D64  = 3'h3;
    localparam logic [2:0] CS_D256 = 3'h4;
    localparam logic [2:0] CS_D1K  = 3'h5;
    localparam logic [2:0] CS_EXTF = 3'h6;
    // Output actions
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR  = 2'h2;
    localparam logic [1:0] ACT_SET    = 2'h3;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_PHASE  = 2'h1,
        MODE_CLEAR  = 2'h2,
        MODE_FAST   = 2'h3
    } tcw_mode_t;

    // Whole block state
    typedef struct packed {
        logic [9:0]  pre;
        logic [2:0]  extSync;
        logic        extLvl;
        logic [2:0]  clkSel;
        logic [1:0]  action;
        tcw_mode_t   mode;
        logic [7:0]  cnt;
        logic [7:0]  cmp;
        logic [7:0]  cmpBuf;
        logic        block;
        logic        oc;
        logic        matchFlag;
        logic        wrapFlag;
        logic        pinDir;
        logic        portData;
        logic        pinOut;
        logic        pinOeN;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } tcw_state_t;
endpackage : tcw_pkg

// >>> hw/tcw_timer8.sv
// Operation
// - A counter write blocks every compare match in the next timer tick.
// - Compare output state keeps its value across waveform mode changes.
// - Output action is not buffered; applies at the first match after writing.
// - System reset clears the compare output state to zero.
// - Nonzero output action replaces port value; direction stays with direction bit.
// - Output action zero leaves compare output unchanged at a match.
// - Force strobe in non-PWM modes applies the action as if matched.
// - Counting follows waveform mode only; action affects only the output.
// - Mode zero always increments, wrapping from 0xFF to 0x00.
// - Mode zero sets wrap flag in the tick the counter becomes zero.
// - Mode 2 clears the counter on a match; compare acts as top.
// - Mode 2 compare writes apply at once; a missed match wraps first.
// - Mode 2 with action 1 toggles the output on every match.
// - Mode 2 sets wrap flag when counting from maximum to 0x00.
// - Mode 3 counts zero up to 0xFF, then clears next tick.
// - Mode 3 sets wrap flag every time it counts from the maximum to 0x00.
// - Mode 3 action two clears at match, sets at restart; three inverts.
// - Mode 3 compare zero gives a spike; compare max gives constant level.
// - Mode 3 action 1 toggles on each match, compare still double buffered.
// - Compare is double buffered at top in PWM modes, direct otherwise.
// - A match sets the match flag; cleared by writing one or acknowledge.
// - A forced match changes only the output, never flag or counter.
// - Clock source zero stops the counter; the CPU still reads and writes it.
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tcw_timer8
    import tcw_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        extClkPin,
    input  wire logic        matchAck,
    input  wire logic        wrapAck,
    output logic             pinOut,
    output logic             pinOeN,
    output logic             compareOut,
    output logic             matchFlag,
    output logic             wrapFlag
);
    tcw_state_t s_r;
    tcw_state_t s_nxt;
    logic       setup;
    logic       wrEn;
    logic       tick;
    logic       pwmMode;
    logic       match;
    logic       cntWr;
    logic       cmpWr;
    logic       ctlWr;
    logic       forceHit;
    logic [1:0] newAct;
    logic [7:0] wByte;

    // Bus phase decode
    assign setup   = psel && !penable;
    assign wrEn    = psel && penable && s_r.pready && pwrite;
    assign wByte   = pwdata[7:0];
    assign cntWr   = wrEn && (paddr == ADDR_COUNT);
    assign cmpWr   = wrEn && (paddr == ADDR_COMPARE);
    assign ctlWr   = wrEn && (paddr == ADDR_CTRL);
    assign pwmMode = s_r.mode[0];
    // Compare hit, suppressed for one tick after a counter write
    assign match   = (s_r.cnt == s_r.cmp) && !s_r.block;
    assign newAct  = wByte[CTRL_COM_LSB +: 2];
    // Force only in non-PWM modes, using the action being written
    assign forceHit = ctlWr && wByte[CTRL_FORCE_BIT]
                      && !(wByte[CTRL_WGM0_BIT]);

    // Timer tick from prescaler or filtered external edge
    always_comb
    begin
        case (s_r.clkSel)
            CS_STOP: tick = 1'b0;
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = (s_r.pre & PRE_MASK_8) == PRE_MASK_8;
            CS_D64:  tick = (s_r.pre & PRE_MASK_64) == PRE_MASK_64;
            CS_D256: tick = (s_r.pre & PRE_MASK_256) == PRE_MASK_256;
            CS_D1K:  tick = s_r.pre == PRE_MASK_1024;
            CS_EXTF: tick = s_r.extLvl && (s_r.extSync[1] == s_r.extSync[2])
                            && !s_r.extSync[2];
            default: tick = !s_r.extLvl && (s_r.extSync[1] == s_r.extSync[2])
                            && s_r.extSync[2];
        endcase
    end

    // Next state
    always_comb
    begin
        s_nxt         = s_r;
        s_nxt.pre     = s_r.pre + 10'h001;
        s_nxt.extSync = {s_r.extSync[1:0], extClkPin};
        if (s_r.extSync[1] == s_r.extSync[2])
        begin
            s_nxt.extLvl = s_r.extSync[2];
        end
        // Blocking window ends at the next tick
        if (tick)
        begin
            s_nxt.block = 1'b0;
        end
        // Counting sequence, set by mode alone
        if (tick)
        begin
            if (s_r.mode == MODE_CLEAR && match)
            begin
                s_nxt.cnt = COUNT_BOTTOM;
            end
            else
            begin
                s_nxt.cnt = s_r.cnt + 8'h01;
            end
            if (s_r.cnt == COUNT_MAX)
            begin
                s_nxt.wrapFlag = 1'b1;
            end
            if (match)
            begin
                s_nxt.matchFlag = 1'b1;
            end
            // Compare buffer moves in at top in PWM modes
            if (pwmMode && s_r.cnt == COUNT_MAX)
            begin
                s_nxt.cmp = s_r.cmpBuf;
            end
        end
        // Output action at a real match
        if (tick && match)
        begin
            case (s_r.action)
                ACT_TOGGLE: s_nxt.oc = !s_r.oc;
                ACT_CLEAR:  s_nxt.oc = 1'b0;
                ACT_SET:    s_nxt.oc = 1'b1;
                default:    s_nxt.oc = s_r.oc;
            endcase
        end
        // Fast PWM restart at bottom overrides the match
        if (tick && s_r.mode == MODE_FAST && s_r.cnt == COUNT_MAX)
        begin
            if (s_r.action == ACT_CLEAR)
            begin
                s_nxt.oc = 1'b1;
            end
            else if (s_r.action == ACT_SET)
            begin
                s_nxt.oc = 1'b0;
            end
        end
        // Forced match: output only, no flag, no counter effect
        if (forceHit)
        begin
            case (newAct)
                ACT_TOGGLE: s_nxt.oc = !s_r.oc;
                ACT_CLEAR:  s_nxt.oc = 1'b0;
                ACT_SET:    s_nxt.oc = 1'b1;
                default:    s_nxt.oc = s_r.oc;
            endcase
        end
        // Control write; output state untouched by mode change
        if (ctlWr)
        begin
            s_nxt.clkSel = wByte[CTRL_CS_LSB +: 3];
            s_nxt.action = newAct;
            s_nxt.mode   = tcw_mode_t'({wByte[CTRL_WGM1_BIT],
                                        wByte[CTRL_WGM0_BIT]});
        end
        // Counter write wins over counting and arms blocking
        if (cntWr)
        begin
            s_nxt.cnt   = wByte;
            s_nxt.block = 1'b1;
        end
        // Compare write: buffer always, live value when not PWM
        if (cmpWr)
        begin
            s_nxt.cmpBuf = wByte;
            if (!pwmMode)
            begin
                s_nxt.cmp = wByte;
            end
        end
        // Flag clears; a set in the same cycle wins
        if (wrEn && paddr == ADDR_FLAGS)
        begin
            if (wByte[FLAG_MATCH_BIT] && !(tick && match))
            begin
                s_nxt.matchFlag = 1'b0;
            end
            if (wByte[FLAG_WRAP_BIT] && !(tick && s_r.cnt == COUNT_MAX))
            begin
                s_nxt.wrapFlag = 1'b0;
            end
        end
        if (matchAck && !(tick && match))
        begin
            s_nxt.matchFlag = 1'b0;
        end
        if (wrapAck && !(tick && s_r.cnt == COUNT_MAX))
        begin
            s_nxt.wrapFlag = 1'b0;
        end
        if (wrEn && paddr == ADDR_PORT)
        begin
            s_nxt.pinDir   = wByte[PORT_DIR_BIT];
            s_nxt.portData = wByte[PORT_DATA_BIT];
        end
        // Pin override by compare output; direction from direction bit
        s_nxt.pinOut = (s_nxt.action != ACT_NONE) ? s_nxt.oc
                                                  : s_nxt.portData;
        s_nxt.pinOeN = !s_nxt.pinDir;
        // Bus answer: ready in the first access cycle
        s_nxt.pready  = setup;
        s_nxt.pslverr = 1'b0;
        s_nxt.prdata  = 32'h0000_0000;
        if (setup)
        begin
            case (paddr)
                ADDR_CTRL:    s_nxt.prdata[7:0] = {1'b0, s_r.mode[0], s_r.action,
                                                   s_r.mode[1], s_r.clkSel};
                ADDR_COUNT:   s_nxt.prdata[7:0] = s_r.cnt;
                ADDR_COMPARE: s_nxt.prdata[7:0] = s_r.cmpBuf;
                ADDR_FLAGS:   s_nxt.prdata[1:0] = {s_r.matchFlag, s_r.wrapFlag};
                ADDR_PORT:    s_nxt.prdata[1:0] = {s_r.portData, s_r.pinDir};
                default:      s_nxt.pslverr     = 1'b1;
            endcase
        end
    end

    // State register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s_r        <= '0;
            s_r.oc     <= 1'b0;
            s_r.pinOeN <= 1'b1;
            s_r.mode   <= MODE_NORMAL;
            s_r.cnt    <= RST_BYTE;
            s_r.cmp    <= RST_BYTE;
            s_r.cmpBuf <= RST_BYTE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign pready     = s_r.pready;
    assign prdata     = s_r.prdata;
    assign pslverr    = s_r.pslverr;
    assign pinOut     = s_r.pinOut;
    assign pinOeN     = s_r.pinOeN;
    assign compareOut = s_r.oc;
    assign matchFlag  = s_r.matchFlag;
    assign wrapFlag   = s_r.wrapFlag;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_block_after_write;
        cntWr |=> !match;
    endproperty
    a_block_after_write: assert property (p_block_after_write)
        else $error("match not blocked after counter write");

    property p_reset_clears_oc;
        rst |=> (compareOut == 1'b0);
    endproperty
    a_reset_clears_oc: assert property (disable iff (1'b0) p_reset_clears_oc)
        else $error("compare output not cleared by reset");

    property p_mode_keeps_oc;
        (ctlWr && !forceHit && !(tick && match) && !(tick && s_r.cnt == COUNT_MAX))
            |=> (compareOut == $past(compareOut));
    endproperty
    a_mode_keeps_oc: assert property (p_mode_keeps_oc)
        else $error("compare output changed by mode write");

    property p_pin_override;
        (s_r.action != ACT_NONE) |-> (pinOut == compareOut);
    endproperty
    a_pin_override: assert property (p_pin_override)
        else $error("pin not driven by compare output");

    property p_normal_wraps;
        (tick && !cntWr && s_r.mode == MODE_NORMAL && s_r.cnt == COUNT_MAX)
            |=> (s_r.cnt == COUNT_BOTTOM) && wrapFlag;
    endproperty
    a_normal_wraps: assert property (p_normal_wraps)
        else $error("normal mode wrap wrong");

    property p_clear_on_match;
        (tick && !cntWr && s_r.mode == MODE_CLEAR && match) |=> (s_r.cnt == COUNT_BOTTOM);
    endproperty
    a_clear_on_match: assert property (p_clear_on_match)
        else $error("counter not cleared on match");

    property p_flag_on_match;
        (tick && match) |=> matchFlag;
    endproperty
    a_flag_on_match: assert property (p_flag_on_match)
        else $error("match flag not set");

    property p_force_no_flag;
        (forceHit && !(tick && match) && !matchFlag && !cntWr)
            |=> !matchFlag && (s_r.cnt == $past(s_r.cnt) + 8'h00 || $past(tick));
    endproperty
    a_force_no_flag: assert property (p_force_no_flag)
        else $error("forced match touched flag or counter");

    property p_stopped_holds;
        (s_r.clkSel == CS_STOP && !cntWr && !ctlWr) |=> $stable(s_r.cnt);
    endproperty
    a_stopped_holds: assert property (p_stopped_holds)
        else $error("counter moved while stopped");

    property p_toggle_clear_mode;
        (tick && match && s_r.mode == MODE_CLEAR && s_r.action == ACT_TOGGLE && !ctlWr)
            |=> (compareOut != $past(compareOut));
    endproperty
    a_toggle_clear_mode: assert property (p_toggle_clear_mode)
        else $error("output did not toggle on match");

    property p_restart_sets;
        (tick && s_r.mode == MODE_FAST && s_r.cnt == COUNT_MAX && s_r.action == ACT_CLEAR
            && !forceHit) |=> compareOut;
    endproperty
    a_restart_sets: assert property (p_restart_sets)
        else $error("output not set at restart");

    property p_restart_clears;
        (tick && s_r.mode == MODE_FAST && s_r.cnt == COUNT_MAX && s_r.action == ACT_SET
            && !forceHit) |=> !compareOut;
    endproperty
    a_restart_clears: assert property (p_restart_clears)
        else $error("output not cleared at restart");

    property p_force_pwm_ignored;
        (ctlWr && wByte[CTRL_FORCE_BIT] && wByte[CTRL_WGM0_BIT] && !tick)
            |=> (compareOut == $past(compareOut));
    endproperty
    a_force_pwm_ignored: assert property (p_force_pwm_ignored)
        else $error("force acted in a PWM mode");

    property p_buffer_at_top;
        (tick && pwmMode && s_r.cnt == COUNT_MAX) |=> (s_r.cmp == $past(s_r.cmpBuf));
    endproperty
    a_buffer_at_top: assert property (p_buffer_at_top)
        else $error("compare buffer not moved in at top");

    property p_direct_compare;
        (cmpWr && !pwmMode) |=> (s_r.cmp == $past(wByte));
    endproperty
    a_direct_compare: assert property (p_direct_compare)
        else $error("compare write not applied at once");

    property p_wrap_at_max;
        (tick && s_r.cnt == COUNT_MAX) |=> wrapFlag;
    endproperty
    a_wrap_at_max: assert property (p_wrap_at_max)
        else $error("wrap flag not set leaving maximum");

    property p_normal_counts;
        (tick && !cntWr && s_r.mode == MODE_NORMAL && s_r.cnt != COUNT_MAX)
            |=> (s_r.cnt == $past(s_r.cnt) + 8'h01);
    endproperty
    a_normal_counts: assert property (p_normal_counts)
        else $error("normal mode did not increment");
endmodule : tcw_timer8
`default_nettype wire

// >>> dv/tcw_pin_load.sv
`timescale 1ns/1ps
`default_nettype none
module tcw_pin_load
(
    input  wire logic pinOut,
    input  wire logic pinOeN,
    output logic      pinLevel
);
    // Pin level seen by the load, pulled low when undriven
    assign pinLevel = (pinOeN == 1'b0) ? pinOut : 1'b0;
endmodule : tcw_pin_load
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import tcw_pkg::*;
;
    logic        sys_clk, rst, psel, penable, pwrite, extClkPin, matchAck, wrapAck;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, pinOut, pinOeN, compareOut, matchFlag, wrapFlag;
    logic        pinLevel, e;
    int          errorCnt, compares, cycles, hi, tg;

    tcw_timer8 tcw_timer8_inst (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .extClkPin(extClkPin), .matchAck(matchAck), .wrapAck(wrapAck),
        .pinOut(pinOut), .pinOeN(pinOeN), .compareOut(compareOut), .matchFlag(matchFlag),
        .wrapFlag(wrapFlag));
    tcw_pin_load tcw_pin_load_inst (.pinOut(pinOut), .pinOeN(pinOeN), .pinLevel(pinLevel));

    // Free running clock
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errorCnt++;
            tallyAndFinish();
        end
    end

    task automatic tallyAndFinish;
        $display("errors %0d compares %0d", errorCnt, compares);
        if (errorCnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tallyAndFinish

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errorCnt++;
            $display("MISMATCH %s exp %0h seen %0h", name, exp, seen);
        end
    endtask : chk

    // One APB transfer, held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        chk("pready", pready, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge sys_clk);
    endtask : apb

    function automatic logic [31:0] ctrl(input logic [1:0] md, input logic [1:0] act,
                                         input logic [2:0] cs, input logic frc);
        return {24'h0, frc, md[0], act, md[1], cs};
    endfunction : ctrl

    // Highs and level changes of the compare output over n cycles
    task automatic watch(input int n);
        logic prev;
        @(negedge sys_clk);
        prev = compareOut;
        hi = 0;
        tg = 0;
        repeat (n)
        begin
            @(negedge sys_clk);
            hi += (compareOut === 1'b1);
            tg += (compareOut !== prev);
            prev = compareOut;
        end
    endtask : watch

    task automatic testReset;
        @(negedge sys_clk);
        chk("compareOut", compareOut, 32'h0);
        chk("pinOeN", pinOeN, 32'h1);
        apb(1'b0, 8'h14, 32'h0);
        chk("slverr", e, 32'h1);
        chk("unmappedData", q, 32'h0);
        $display("test reset done");
    endtask : testReset

    task automatic testForce;
        apb(1'b1, ADDR_COUNT, 32'h33);
        apb(1'b1, ADDR_PORT, 32'h1);
        apb(1'b1, ADDR_CTRL, ctrl(MODE_NORMAL, ACT_SET, CS_STOP, 1'b1));
        chk("forced", compareOut, 32'h1);
        chk("matchFlag", matchFlag, 32'h0);
        chk("pinLevel", pinLevel, 32'h1);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk("count", q, 32'h33);
        apb(1'b1, ADDR_CTRL, ctrl(MODE_FAST, ACT_CLEAR, CS_STOP, 1'b1));
        chk("keep", compareOut, 32'h1);
        apb(1'b1, ADDR_CTRL, ctrl(MODE_NORMAL, ACT_NONE, CS_STOP, 1'b0));
        chk("portData0", pinLevel, 32'h0);
        apb(1'b1, ADDR_PORT, 32'h3);
        chk("portData1", pinLevel, 32'h1);
        apb(1'b1, ADDR_PORT, 32'h2);
        chk("pinOff", pinOeN, 32'h1);
        chk("pinFloat", pinLevel, 32'h0);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        chk("resetOc", compareOut, 32'h0);
        $display("test force done");
    endtask : testForce

    task automatic testWrap;
        int n;
        n = 0;
        apb(1'b1, ADDR_FLAGS, 32'h3);
        apb(1'b1, ADDR_COUNT, 32'hFE);
        apb(1'b1, ADDR_CTRL, ctrl(MODE_NORMAL, ACT_NONE, CS_DIV1, 1'b0));
        while (wrapFlag !== 1'b1 && n < 20)
        begin
            @(negedge sys_clk);
            n++;
        end
        chk("wrapTime", n, 32'h2);
        apb(1'b1, ADDR_CTRL, ctrl(MODE_NORMAL, ACT_NONE, CS_STOP, 1'b0));
        apb(1'b0, ADDR_COUNT, 32'h0);
        tg = q;
        cyc(20);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk("stopped", q, tg);
        apb(1'b1, ADDR_COUNT, 32'h5A);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk("stoppedWrite", q, 32'h5A);
        chk("wrapHeld", wrapFlag, 32'h1);
        apb(1'b1, ADDR_FLAGS, 32'h1);
        chk("wrapClr", wrapFlag, 32'h0);
        $display("test wrap done");
    endtask : testWrap

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc

    task automatic testBlock;
        apb(1'b1, ADDR_FLAGS, 32'h3);
        apb(1'b1, ADDR_COMPARE, 32'h10);
        apb(1'b1, ADDR_COUNT, 32'h10);
        apb(1'b1, ADDR_CTRL, ctrl(MODE_NORMAL, ACT_NONE, CS_DIV1, 1'b0));
        cyc(40);
        apb(1'b1, ADDR_CTRL, ctrl(MODE_NORMAL, ACT_NONE, CS_STOP, 1'b0));
        chk("blocked", matchFlag, 32'h0);
        apb(1'b1, ADDR_COUNT, 32'h0F);
        apb(1'b1, ADDR_CTRL, ctrl(MODE_NORMAL, ACT_NONE, CS_DIV1, 1'b0));
        cyc(4);
        chk("oneTick", matchFlag, 32'h1);
        $display("test block done");
    endtask : testBlock

    task automatic testClear;
        apb(1'b1, ADDR_CTRL, ctrl(MODE_CLEAR, ACT_NONE, CS_STOP, 1'b0));
        apb(1'b1, ADDR_FLAGS, 32'h3);
        apb(1'b1, ADDR_COMPARE, 32'h3);
        apb(1'b1, ADDR_COUNT, 32'h0);
        apb(1'b1, ADDR_CTRL, ctrl(MODE_CLEAR, ACT_NONE, CS_DIV1, 1'b0));
        watch(16);
        chk("noAction", tg, 32'h0);
        apb(1'b1, ADDR_CTRL, ctrl(MODE_CLEAR, ACT_TOGGLE, CS_DIV1, 1'b0));
        watch(16);
        chk("toggles", tg, 32'h4);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk("belowTop", q[7:0] <= 8'h03, 32'h1);
        apb(1'b1, ADDR_CTRL, ctrl(MODE_CLEAR, ACT_NONE, CS_STOP, 1'b0));
        chk("matchSet", matchFlag, 32'h1);
        @(posedge sys_clk);
        matchAck <= 1'b1;
        @(posedge sys_clk);
        matchAck <= 1'b0;
        @(negedge sys_clk);
        chk("matchAck", matchFlag, 32'h0);
        apb(1'b1, ADDR_FLAGS, 32'h3);
        apb(1'b1, ADDR_COUNT, 32'h80);
        apb(1'b1, ADDR_CTRL, ctrl(MODE_CLEAR, ACT_NONE, CS_DIV1, 1'b0));
        cyc(140);
        chk("missWrap", wrapFlag, 32'h1);
        $display("test clear done");
    endtask : testClear

    task automatic testPwm;
        logic [1:0] acts[6] = '{ACT_CLEAR, ACT_SET, ACT_CLEAR, ACT_CLEAR, ACT_SET, ACT_TOGGLE};
        logic [7:0] cmps[6] = '{8'h40, 8'h40, 8'h00, 8'hFF, 8'hFF, 8'h40};
        int         his[6] = '{65, 191, 1, 256, 0, -1};
        int         tgs[6] = '{2, 2, 2, 0, 0, 1};
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, ADDR_CTRL, ctrl(MODE_FAST, acts[i], CS_DIV1, 1'b0));
            apb(1'b1, ADDR_COMPARE, {24'h0, cmps[i]});
            cyc(300);
            watch(256);
            if (his[i] >= 0)
                chk("highs", hi, his[i]);
            chk("edges", tg, tgs[i]);
        end
        $display("test pwm done");
    endtask : testPwm

    // Reset, then the scenarios in turn
    initial
    begin
        {rst, psel, penable, pwrite, extClkPin, matchAck, wrapAck} = 7'h40;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        testReset();
        testForce();
        testWrap();
        testBlock();
        testClear();
        testPwm();
        tallyAndFinish();
    end
endmodule : tb
`default_nettype wire
